// >>> design/gosm_pin_sel.sv
`timescale 1ns/100ps
`include "gosm_map.svh"
// One pin's source mux; registered level and enable
module gosm_pin_sel (
    input  wire logic       clk_sys_i,      // System clock
    input  wire logic       sys_rst_i,      // Async reset, high
    input  wire logic [7:0] ctl_i,          // Pin control register
    input  wire logic [3:0] rx_gpio0_i,     // Remote GPIO 0 per rx port
    input  wire logic [3:0] rx_gpio1_i,     // Remote GPIO 1 per rx port
    input  wire logic [3:0] rx_gpio2_i,     // Remote GPIO 2 per rx port
    input  wire logic [3:0] rx_gpio3_i,     // Remote GPIO 3 per rx port
    input  wire logic [3:0] rx_lock_i,      // Lock per rx port
    input  wire logic [3:0] rx_pass_i,      // Pass per rx port
    input  wire logic [3:0] rx_fv_i,        // Frame valid per rx port
    input  wire logic [3:0] rx_lv_i,        // Line valid per rx port
    input  wire logic [7:0] stat_i,         // Device status vector, by selection
    input  wire logic [7:0] tx0_i,          // Tx port 0 vector, by selection
    input  wire logic [7:0] tx1_i,          // Tx port 1 vector, by selection
    output logic            pin_o,          // Registered pin level
    output logic            pin_oe_o        // Registered pin enable
);
    logic [2:0] sel;
    logic [2:0] src;
    logic [1:0] port;
    logic [7:0] rx_vec;
    logic       pin_next;
    logic       pin_reg;
    logic       oe_reg;

    assign sel  = ctl_i[`GOSM_SEL_HI:`GOSM_SEL_LO];
    assign src  = ctl_i[`GOSM_SRC_HI:`GOSM_SRC_LO];
    assign port = src[1:0];

    // Receive port vector, indexed by selection
    // rx selection map
    assign rx_vec = {rx_lv_i[port], rx_fv_i[port], rx_pass_i[port], rx_lock_i[port],
                     rx_gpio3_i[port], rx_gpio2_i[port], rx_gpio1_i[port], rx_gpio0_i[port]};

    // Source group decode; reserved codes give low
    always_comb begin
        case (gosm_pkg::gosm_src_t'(src))
            gosm_pkg::GOSM_SRC_RX0,
            gosm_pkg::GOSM_SRC_RX1,
            gosm_pkg::GOSM_SRC_RX2,
            gosm_pkg::GOSM_SRC_RX3:    pin_next = rx_vec[sel];
            gosm_pkg::GOSM_SRC_STATUS: pin_next = stat_i[sel];
            gosm_pkg::GOSM_SRC_TX0:    pin_next = tx0_i[sel];
            gosm_pkg::GOSM_SRC_TX1:    pin_next = tx1_i[sel];
            default:                   pin_next = 1'b0;
        endcase
    end

    // Outputs registered so the pin never glitches on a decode change
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            pin_reg <= pin_next;
            oe_reg  <= ctl_i[`GOSM_EN_BIT];
        end
    end

    assign pin_o    = pin_reg;
    assign pin_oe_o = oe_reg;
endmodule

// >>> design/gosm_top.sv
`timescale 1ns/100ps
`include "gosm_map.svh"
module gosm_top (
    input  wire logic       clk_sys_i,      // System clock, 125 MHz
    input  wire logic       sys_rst_i,      // Async reset, high
    input  wire logic [7:0] reg_addr_i,     // Register address
    input  wire logic [7:0] reg_wdata_i,    // Write data
    input  wire logic       reg_wr_i,       // Write strobe
    input  wire logic       reg_rd_i,       // Read strobe
    output logic      [7:0] reg_rdata_o,    // Read data, cycle after strobe
    input  wire logic [3:0] rx_gpio0_i,     // Received remote GPIO 0, per port
    input  wire logic [3:0] rx_gpio1_i,     // Received remote GPIO 1, per port
    input  wire logic [3:0] rx_gpio2_i,     // Received remote GPIO 2, per port
    input  wire logic [3:0] rx_gpio3_i,     // Received remote GPIO 3, per port
    input  wire logic [3:0] rx_lock_i,      // Rx port lock
    input  wire logic [3:0] rx_pass_i,      // Rx port pass
    input  wire logic [3:0] rx_fv_i,        // Rx port frame valid
    input  wire logic [3:0] rx_lv_i,        // Rx port line valid
    input  wire logic [3:0] rx_port_en_i,   // Rx ports enabled
    input  wire logic       frame_sync_signal_i, // Frame sync level
    input  wire logic [3:0] tx0_port_map_i, // Rx ports mapped to tx 0
    input  wire logic [3:0] tx1_port_map_i, // Rx ports mapped to tx 1
    input  wire logic [1:0] tx_fv_i,        // Tx frame valid, per tx port
    input  wire logic [1:0] tx_lv_i,        // Tx line valid, per tx port
    input  wire logic [1:0] tx_sync_i,      // Tx multi-port synchronized
    input  wire logic [1:0] tx_irq_i,       // Tx port interrupt
    output logic            pin5_o,         // Pin 5 level
    output logic            pin5_oe_o,      // Pin 5 drive enable
    output logic            pin6_o,         // Pin 6 level
    output logic            pin6_oe_o       // Pin 6 drive enable
);
    logic [7:0] pin5_ctl_reg;
    logic [7:0] pin5_ctl_next;
    logic [7:0] pin6_ctl_reg;
    logic [7:0] pin6_ctl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [3:0] gp0_s1, gp0_s2, gp1_s1, gp1_s2, gp2_s1, gp2_s2, gp3_s1, gp3_s2;
    logic [3:0] lk_s1, lk_s2, ps_s1, ps_s2, fv_s1, fv_s2, lv_s1, lv_s2;
    logic       fs_s1, fs_s2;
    logic [1:0] tfv_s1, tfv_s2, tlv_s1, tlv_s2, tsy_s1, tsy_s2, tir_s1, tir_s2;
    logic [3:0] en_s1, en_s2;                       // Enabled rx ports, synced
    logic [3:0] map0_s1, map0_s2, map1_s1, map1_s2; // Tx port maps, synced
    logic [2:0] lock_pass;                          // {pass all, lock all, lock any}
    logic [1:0] tx0_pass;                           // {OR, AND} of pass into tx 0
    logic [1:0] tx1_pass;                           // {OR, AND} of pass into tx 1
    logic [1:0] addr_hit;                           // {pin 6, pin 5} address match
    logic       pin5_val;
    logic       pin6_val;
    logic [7:0] stat5;
    logic [7:0] stat6;
    logic [7:0] tx0_vec;
    logic [7:0] tx1_vec;

    // remote GPIO levels cross in through two flops; only stage 2 is read
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {gp0_s1, gp0_s2, gp1_s1, gp1_s2, gp2_s1, gp2_s2, gp3_s1, gp3_s2} <= 32'h0;
        end else begin
            {gp0_s1, gp1_s1, gp2_s1, gp3_s1} <= {rx_gpio0_i, rx_gpio1_i, rx_gpio2_i, rx_gpio3_i};
            {gp0_s2, gp1_s2, gp2_s2, gp3_s2} <= {gp0_s1, gp1_s1, gp2_s1, gp3_s1};
        end
    end

    // rx port lock, pass and video timing, same two stages
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {lk_s1, lk_s2, ps_s1, ps_s2, fv_s1, fv_s2, lv_s1, lv_s2} <= 32'h0;
        end else begin
            {lk_s1, ps_s1, fv_s1, lv_s1} <= {rx_lock_i, rx_pass_i, rx_fv_i, rx_lv_i};
            {lk_s2, ps_s2, fv_s2, lv_s2} <= {lk_s1, ps_s1, fv_s1, lv_s1};
        end
    end

    // frame sync and port enables; enables are pins too, so they are synced as well
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {fs_s1, fs_s2} <= 2'h0;
            {en_s1, en_s2} <= 8'h00;
        end else begin
            fs_s1 <= frame_sync_signal_i;
            fs_s2 <= fs_s1;
            en_s1 <= rx_port_en_i;
            en_s2 <= en_s1;
        end
    end

    // tx port status and port maps; a map change may show mixed bits for one cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {tfv_s1, tfv_s2, tlv_s1, tlv_s2, tsy_s1, tsy_s2, tir_s1, tir_s2} <= 16'h0;
            {map0_s1, map0_s2, map1_s1, map1_s2}                             <= 16'h0;
        end else begin
            {tfv_s1, tlv_s1, tsy_s1, tir_s1} <= {tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i};
            {tfv_s2, tlv_s2, tsy_s2, tir_s2} <= {tfv_s1, tlv_s1, tsy_s1, tir_s1};
            {map0_s1, map1_s1}               <= {tx0_port_map_i, tx1_port_map_i};
            {map0_s2, map1_s2}               <= {map0_s1, map1_s1};
        end
    end

    // Lock/pass combining over enabled ports; an empty set gives low
    function automatic logic [2:0] stat_comb(input logic [3:0] en,
                                             input logic [3:0] lk,
                                             input logic [3:0] ps);
        logic any;
        any = |en;
        stat_comb = {any & (&(ps | ~en)), any & (&(lk | ~en)), |(lk & en)};
    endfunction

    // Pass AND/OR over rx ports mapped to a tx port
    function automatic logic [1:0] pass_comb(input logic [3:0] map, input logic [3:0] ps);
        pass_comb = {|(ps & map), (|map) & (&(ps | ~map))};
    endfunction

    // Address decode shared by the write and read paths
    function automatic logic [1:0] reg_hit(input logic [7:0] addr);
        reg_hit = {addr == `GOSM_PIN6_CTL_OFFSET, addr == `GOSM_PIN5_CTL_OFFSET};
    endfunction

    // One decode feeds both paths, so a write and a read can never disagree on a register
    assign addr_hit = reg_hit(reg_addr_i);

    assign lock_pass = stat_comb(en_s2, lk_s2, ps_s2);
    assign stat5     = {3'h0, fs_s2, lock_pass, pin5_ctl_reg[`GOSM_VAL_BIT]};
    assign stat6     = {3'h0, fs_s2, lock_pass, pin6_ctl_reg[`GOSM_VAL_BIT]};

    // tx selection map, 110 and 111 low
    assign tx0_pass = pass_comb(map0_s2, ps_s2);
    assign tx1_pass = pass_comb(map1_s2, ps_s2);
    assign tx0_vec  = {2'h0, tir_s2[0], tsy_s2[0], tlv_s2[0], tfv_s2[0], tx0_pass};
    assign tx1_vec  = {2'h0, tir_s2[1], tsy_s2[1], tlv_s2[1], tfv_s2[1], tx1_pass};

    // Register writes and read-back; unmapped reads return zero
    always_comb begin
        pin5_ctl_next = pin5_ctl_reg;
        pin6_ctl_next = pin6_ctl_reg;
        rdata_next    = 8'h00;
        // all eight bits stored as written
        if (reg_wr_i) begin
            if (addr_hit[0]) begin
                pin5_ctl_next = reg_wdata_i;
            end
            if (addr_hit[1]) begin
                pin6_ctl_next = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            case (addr_hit)
                2'b01:   rdata_next = pin5_ctl_reg;
                2'b10:   rdata_next = pin6_ctl_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin5_ctl_reg <= `GOSM_CTL_RESET;
            pin6_ctl_reg <= `GOSM_CTL_RESET;
            rdata_reg    <= 8'h00;
        end else begin
            pin5_ctl_reg <= pin5_ctl_next;
            pin6_ctl_reg <= pin6_ctl_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // Pin 5 mux
    gosm_pin_sel u_pin5 (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .ctl_i      (pin5_ctl_reg),
        .rx_gpio0_i (gp0_s2),
        .rx_gpio1_i (gp1_s2),
        .rx_gpio2_i (gp2_s2),
        .rx_gpio3_i (gp3_s2),
        .rx_lock_i  (lk_s2),
        .rx_pass_i  (ps_s2),
        .rx_fv_i    (fv_s2),
        .rx_lv_i    (lv_s2),
        .stat_i     (stat5),
        .tx0_i      (tx0_vec),
        .tx1_i      (tx1_vec),
        .pin_o      (pin5_val),
        .pin_oe_o   (pin5_oe_o)
    );

    // Pin 6 mux, same structure
    // own register, own mux
    gosm_pin_sel u_pin6 (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .ctl_i      (pin6_ctl_reg),
        .rx_gpio0_i (gp0_s2),
        .rx_gpio1_i (gp1_s2),
        .rx_gpio2_i (gp2_s2),
        .rx_gpio3_i (gp3_s2),
        .rx_lock_i  (lk_s2),
        .rx_pass_i  (ps_s2),
        .rx_fv_i    (fv_s2),
        .rx_lv_i    (lv_s2),
        .stat_i     (stat6),
        .tx0_i      (tx0_vec),
        .tx1_i      (tx1_vec),
        .pin_o      (pin6_val),
        .pin_oe_o   (pin6_oe_o)
    );

    assign pin5_o = pin5_val;
    assign pin6_o = pin6_val;
endmodule

// >>> inc/gosm_map.svh
`ifndef GOSM_MAP_SVH
`define GOSM_MAP_SVH
// Register offsets (byte addresses on the plain register port)
`define GOSM_PIN5_CTL_OFFSET   8'h15
`define GOSM_PIN6_CTL_OFFSET   8'h16
// Field positions inside a pin control register
`define GOSM_SEL_HI            7
`define GOSM_SEL_LO            5
`define GOSM_SRC_HI            4
`define GOSM_SRC_LO            2
`define GOSM_VAL_BIT           1
`define GOSM_EN_BIT            0
// Reset value of both pin control registers
`define GOSM_CTL_RESET         8'h00
`endif

// >>> inc/gosm_pkg.sv
package gosm_pkg;
    // Source group codes
    typedef enum logic [2:0] {
        GOSM_SRC_RX0    = 3'h0,
        GOSM_SRC_RX1    = 3'h1,
        GOSM_SRC_RX2    = 3'h2,
        GOSM_SRC_RX3    = 3'h3,
        GOSM_SRC_STATUS = 3'h4,
        GOSM_SRC_RSVD   = 3'h5,
        GOSM_SRC_TX0    = 3'h6,
        GOSM_SRC_TX1    = 3'h7
    } gosm_src_t;
endpackage

// >>> testbench/gosm_board.sv
`timescale 1ns/100ps
// Board side of both pins: resolves each wire from its driver
module gosm_board (
    input  wire logic clk_sys_i, // Clock
    input  wire logic pin5_i,    // Pin 5 level
    input  wire logic pin5_oe_i, // Pin 5 enable
    input  wire logic pin6_i,    // Pin 6 level
    input  wire logic pin6_oe_i, // Pin 6 enable
    output logic      wire5_o,   // Pin 5 wire
    output logic      wire6_o    // Pin 6 wire
);
    logic flip_reg = 1'b0;
    // No pull on the pins, so a floating wire toggles rather than hold a stale level
    always_ff @(posedge clk_sys_i) begin
        flip_reg <= ~flip_reg;
    end
    assign wire5_o = pin5_oe_i ? pin5_i : flip_reg;
    assign wire6_o = pin6_oe_i ? pin6_i : flip_reg;
endmodule

// >>> testbench/gosm_chk.sv
`timescale 1ns/100ps
// Port-level checks of register access and pin muxing
module gosm_chk (
    input wire logic       clk_sys_i, // Clock
    input wire logic       sys_rst_i, // Reset
    input wire logic [7:0] reg_addr_i, // Address
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic       reg_wr_i, // Write strobe
    input wire logic       reg_rd_i, // Read strobe
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic       frame_sync_signal_i, // Frame sync
    input wire logic       pin5_o, // Pin 5 level
    input wire logic       pin5_oe_o, // Pin 5 enable
    input wire logic       pin6_o, // Pin 6 level
    input wire logic       pin6_oe_o // Pin 6 enable
);
    logic [7:0] c5_reg, c6_reg;
    logic       w5, w6, rsv6;
    // Shadow copies of both controls, so checks need no internal probes
    assign w5 = reg_wr_i && reg_addr_i == 8'h15;
    assign w6 = reg_wr_i && reg_addr_i == 8'h16;
    // Reserved source or selection codes on pin 6
    assign rsv6 = c6_reg[4:2] == 3'h5 || (c6_reg[4:2] == 3'h4 && c6_reg[7:5] > 3'h4)
                  || (c6_reg[4:3] == 2'h3 && c6_reg[7:6] == 2'h3);
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c5_reg <= 8'h00;
            c6_reg <= 8'h00;
        end else begin
            c5_reg <= w5 ? reg_wdata_i : c5_reg;
            c6_reg <= w6 ? reg_wdata_i : c6_reg;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // Pins and reads judged against reset, the write port and the shadows
    a_reset_undriven: assert property ($fell(sys_rst_i) |-> !pin5_oe_o && !pin6_oe_o)
        else $error("pin driven after reset");
    a_oe_write: assert property (w5 |=> ##1 pin5_oe_o == $past(reg_wdata_i[0], 2))
        else $error("pin 5 enable missed its write");
    a_oe6_cause: assert property ($changed(pin6_oe_o) |-> $past(w6, 2))
        else $error("pin 6 enable moved without a write");
    a_read_shadow: assert property (reg_rd_i && reg_addr_i == 8'h16 |=> reg_rdata_o == $past(c6_reg))
        else $error("pin 6 control read back wrong");
    a_read_unmapped: assert property (reg_rd_i && reg_addr_i > 8'h16 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_local_value: assert property ((c5_reg[7:2] == 6'h04) [*2]
        |-> pin5_o == $past(c5_reg[1]) && pin5_oe_o == $past(c5_reg[0]))
        else $error("pin 5 local value wrong");
    a_sync_lag: assert property ((c5_reg == 8'h91) [*3] |-> pin5_o == $past(frame_sync_signal_i, 3))
        else $error("pin 5 frame sync lag wrong");
    a_reserved_low: assert property (rsv6 [*2] |-> !pin6_o)
        else $error("pin 6 reserved code not low");
endmodule

bind gosm_top gosm_chk chk (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .frame_sync_signal_i, .pin5_o, .pin5_oe_o, .pin6_o, .pin6_oe_o);

// >>> testbench/test_gosm_top.sv
`timescale 1ns/100ps
// Register port and pin mux checks on both pins
module test_gosm_top;
    logic       clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, frame_sync_signal_i, wire5, wire6;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [3:0] rx_gpio0_i, rx_gpio1_i, rx_gpio2_i, rx_gpio3_i, rx_lock_i, rx_pass_i, rx_fv_i, rx_lv_i;
    logic [3:0] rx_port_en_i, tx0_port_map_i, tx1_port_map_i;
    logic [1:0] tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i;
    logic       pin5_o, pin5_oe_o, pin6_o, pin6_oe_o;
    int         errors = 0, compares = 0;
    gosm_top uut (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .rx_gpio0_i, .rx_gpio1_i, .rx_gpio2_i, .rx_gpio3_i, .rx_lock_i, .rx_pass_i, .rx_fv_i, .rx_lv_i,
        .rx_port_en_i, .frame_sync_signal_i, .tx0_port_map_i, .tx1_port_map_i, .tx_fv_i, .tx_lv_i,
        .tx_sync_i, .tx_irq_i, .pin5_o, .pin5_oe_o, .pin6_o, .pin6_oe_o);
    gosm_board board (.clk_sys_i, .pin5_i(pin5_o), .pin5_oe_i(pin5_oe_o), .pin6_i(pin6_o),
        .pin6_oe_i(pin6_oe_o), .wire5_o(wire5), .wire6_o(wire6));
    // 125 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 cmp(reg_rdata_o, exp);
    endtask
    function automatic logic all_of(input logic [3:0] v, input logic [3:0] e);
        return e != 4'h0 && (v & e) == e;
    endfunction
    // Expected pin level for a control value, from the current inputs
    function automatic logic ref_pin(input logic [7:0] c);
        logic [3:0] rv [8];
        logic [3:0] m;
        logic [7:0] st, tx;
        rv = '{rx_gpio0_i, rx_gpio1_i, rx_gpio2_i, rx_gpio3_i, rx_lock_i, rx_pass_i, rx_fv_i, rx_lv_i};
        m = c[2] ? tx1_port_map_i : tx0_port_map_i;
        st = {3'h0, frame_sync_signal_i, all_of(rx_pass_i, rx_port_en_i), all_of(rx_lock_i, rx_port_en_i),
              |(rx_lock_i & rx_port_en_i), c[1]};
        tx = {2'h0, tx_irq_i[c[2]], tx_sync_i[c[2]], tx_lv_i[c[2]], tx_fv_i[c[2]], |(rx_pass_i & m),
              all_of(rx_pass_i, m)};
        case (c[4:2])
            3'h4: return st[c[7:5]];
            3'h5: return 1'b0;
            3'h6, 3'h7: return tx[c[7:5]];
            default: return rv[c[7:5]][c[3:2]];
        endcase
    endfunction
    // Every selection of the given source groups, enabled, seen on the wire
    task automatic sweep(input logic [7:0] a, input int lo, input int hi, input logic v);
        logic [7:0] c;
        for (int s = lo; s <= hi; s++) begin
            for (int k = 0; k < 8; k++) begin
                c = {3'(k), 3'(s), v, 1'b1};
                wr(a, c);
                repeat (3) @(posedge clk_sys_i);
                #1 cmp({7'h00, a[0] ? wire5 : wire6}, {7'h00, ref_pin(c)});
            end
        end
    endtask
    task automatic t_regs;
        #1 cmp({6'h00, pin5_oe_o, pin6_oe_o}, 8'h00);
        rd(8'h15, 8'h00);
        rd(8'h16, 8'h00);
        wr(8'h15, 8'ha5);
        wr(8'h16, 8'h3c);
        wr(8'h17, 8'hff);
        rd(8'h15, 8'ha5);
        rd(8'h16, 8'h3c);
        rd(8'h17, 8'h00);
        cmp({6'h00, pin5_oe_o, pin6_oe_o}, 8'h02);
    endtask
    task automatic t_rx;
        for (int n = 0; n < 2; n++) begin
            @(posedge clk_sys_i);
            {rx_lv_i, rx_fv_i, rx_pass_i, rx_lock_i, rx_gpio3_i, rx_gpio2_i, rx_gpio1_i, rx_gpio0_i}
                <= n ? 32'h6f18a3c5 : 32'ha7e14b85;
            sweep(8'h15, 0, 3, 1'(n));
            sweep(8'h16, 0, 3, 1'(n));
        end
    endtask
    task automatic t_stat;
        @(posedge clk_sys_i);
        {rx_port_en_i, rx_lock_i, rx_pass_i, frame_sync_signal_i} <= 13'h0a8b;
        sweep(8'h15, 4, 5, 1'b1);
        @(posedge clk_sys_i);
        {rx_port_en_i, rx_lock_i, rx_pass_i, frame_sync_signal_i} <= 13'h0ba8;
        sweep(8'h16, 4, 5, 1'b0);
        wr(8'h15, 8'h91);
        repeat (8) begin
            repeat (3) @(posedge clk_sys_i);
            frame_sync_signal_i <= ~frame_sync_signal_i;
        end
        repeat (4) @(posedge clk_sys_i);
        #1 cmp({7'h00, wire5}, {7'h00, frame_sync_signal_i});
    endtask
    task automatic t_tx;
        @(posedge clk_sys_i);
        {tx0_port_map_i, tx1_port_map_i, rx_pass_i, tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i} <= 20'h3c766;
        sweep(8'h16, 6, 7, 1'b1);
        @(posedge clk_sys_i);
        {tx0_port_map_i, tx1_port_map_i, rx_pass_i, tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i} <= 20'h3cc99;
        sweep(8'h15, 6, 7, 1'b0);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well beyond the expected run
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        errors++;
        wrap_up;
    end
    initial begin
        {sys_rst_i, reg_wr_i, reg_rd_i, frame_sync_signal_i, reg_addr_i, reg_wdata_i} = 20'h80000;
        {rx_lv_i, rx_fv_i, rx_pass_i, rx_lock_i, rx_gpio3_i, rx_gpio2_i, rx_gpio1_i, rx_gpio0_i} = 32'h0;
        {rx_port_en_i, tx0_port_map_i, tx1_port_map_i, tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i} = 20'h0;
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_regs;
        t_rx;
        t_stat;
        t_tx;
        // A second reset mid-run must clear the pin 6 control again
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(8'h16, 8'h00);
        wrap_up;
    end
endmodule
